// ===== hdl/arc_pkg.sv
package arc_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int RES_W  = 12;
  localparam int PINS   = 8;
  localparam int DIV_W  = 7;

  localparam logic [ADDR_W-1:0] OFS_RESULT_LOW  = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_RESULT_HIGH = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CONV_CTRL   = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_SRC_CLK     = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_REF_CTRL    = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_PIN_ANALOG  = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS  = 3'h6;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK    = 3'h7;

  localparam int CC_START = 7;
  localparam int CC_BUSY  = 6;
  localparam int CC_EN    = 5;
  localparam int CC_ALIGN = 4;
  localparam int CC_CH_LO = 0;
  localparam int SC_SRC_LO = 5;
  localparam int SC_DIV_LO = 0;
  localparam int INT_DONE  = 0;
  localparam int INT_ABORT = 1;

  localparam logic [DATA_W-1:0] CONV_CTRL_RST  = 8'h00;
  localparam logic [DATA_W-1:0] SRC_CLK_RST    = 8'h00;
  localparam logic [DATA_W-1:0] REF_CTRL_RST   = 8'h00;
  localparam logic [DATA_W-1:0] PIN_ANALOG_RST = 8'hff;
  localparam logic [DATA_W-1:0] INT_RST        = 8'h00;
  localparam logic [RES_W-1:0]  RESULT_RST     = 12'h000;
  localparam logic [DIV_W-1:0]  DIV_ONE        = 7'h01;

  localparam logic [2:0] SRC_EXT_A = 3'h0;
  localparam logic [2:0] SRC_EXT_B = 3'h4;

  typedef struct packed {
    logic       start;
    logic       busy;
    logic       enable;
    logic       align;
    logic [2:0] channel;
  } arc_ctrl_t;

  typedef struct packed {
    logic       amp_en;
    logic       bandgap_en;
    logic       vrefi_in_en;
    logic       vref_out_en;
    logic [3:0] ref_src;
  } arc_ref_t;

  typedef struct packed {
    logic       ext_path_on;
    logic [2:0] ext_channel;
    logic       int_path_on;
    logic [2:0] int_source;
  } arc_mux_t;

endpackage : arc_pkg

// ===== hdl/arc_adc_register_control.sv
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
module arc_adc_register_control
  import arc_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      rstn,
  input  wire logic [arc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [arc_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [arc_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                      conv_done,
  input  wire logic [arc_pkg::RES_W-1:0]  conv_data,
  output logic                           conv_power_on,
  output logic                           conv_reset,
  output logic                           conv_start,
  output logic                           conv_clk_tick,
  output arc_pkg::arc_mux_t              mux_sel,
  output arc_pkg::arc_ref_t              ref_cfg,
  output logic      [arc_pkg::PINS-1:0]   pin_analog_sel,
  output logic      [arc_pkg::PINS-1:0]   pin_pull_high_off,
  output logic                           irq
);
  import arc_pkg::*;

  arc_ctrl_t           ctrl_r;
  logic [DATA_W-1:0]   src_clk_r;
  arc_ref_t            ref_r;
  logic [PINS-1:0]     pin_r;
  logic [RES_W-1:0]    result_r;
  logic [DATA_W-1:0]   int_status_r;
  logic [DATA_W-1:0]   int_mask_r;
  logic [DIV_W-1:0]    div_cnt_r;
  logic [DATA_W-1:0]   rdata_nxt;

  logic                ctrl_wr;
  arc_ctrl_t           ctrl_wd;
  logic                en_nxt;
  logic                src_wr;
  logic                ref_wr;
  logic                pin_wr;
  logic                mask_wr;
  logic                stat_wr;
  logic                div_wrap;
  logic [DATA_W-1:0]   int_event;
  logic [DATA_W-1:0]   stat_clr;
  logic                start_rise;
  logic                start_fall;
  logic                done_ev;
  logic                abort_ev;
  logic [2:0]          src_sel;
  logic [2:0]          div_sel;
  logic                src_is_ext;
  logic [DIV_W-1:0]    div_top;

  assign ctrl_wr    = reg_wr && (reg_addr == OFS_CONV_CTRL);
  assign en_nxt     = ctrl_wr ? ctrl_wd.enable : ctrl_r.enable;
  assign src_wr     = reg_wr && (reg_addr == OFS_SRC_CLK);
  assign ref_wr     = reg_wr && (reg_addr == OFS_REF_CTRL);
  assign pin_wr     = reg_wr && (reg_addr == OFS_PIN_ANALOG);
  assign mask_wr    = reg_wr && (reg_addr == OFS_INT_MASK);
  assign stat_wr    = reg_wr && (reg_addr == OFS_INT_STATUS);
  assign stat_clr   = stat_wr ? reg_wdata : '0;
  assign start_rise = ctrl_wr && !ctrl_r.start && ctrl_wd.start;
  // A fall only starts when the enable written with it is set.
  assign start_fall = ctrl_wr && ctrl_r.start && !ctrl_wd.start && ctrl_wd.enable;
  assign done_ev    = conv_done && ctrl_r.busy && ctrl_r.enable;
  assign abort_ev   = start_rise && ctrl_r.busy;
  assign src_sel    = src_clk_r[SC_SRC_LO +: 3];
  assign div_sel    = src_clk_r[SC_DIV_LO +: 3];
  assign src_is_ext = (src_sel == SRC_EXT_A) || (src_sel == SRC_EXT_B);
  assign div_top    = DIV_W'((8'h01 << div_sel) - 8'h01);
  assign div_wrap   = (div_cnt_r >= div_top);

  // Control write data by field; bit 3 of the bus has no slot in the struct.
  always_comb
  begin
    ctrl_wd         = '0;
    ctrl_wd.start   = reg_wdata[CC_START];
    ctrl_wd.busy    = reg_wdata[CC_BUSY];
    ctrl_wd.enable  = reg_wdata[CC_EN];
    ctrl_wd.align   = reg_wdata[CC_ALIGN];
    ctrl_wd.channel = reg_wdata[CC_CH_LO +: 3];
  end

  // Control register; busy is never written by software.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r.start   <= CONV_CTRL_RST[CC_START];
      ctrl_r.busy    <= CONV_CTRL_RST[CC_BUSY];
      ctrl_r.enable  <= CONV_CTRL_RST[CC_EN];
      ctrl_r.align   <= CONV_CTRL_RST[CC_ALIGN];
      ctrl_r.channel <= CONV_CTRL_RST[CC_CH_LO +: 3];
    end
    else
    begin
      if (ctrl_wr)
      begin
        ctrl_r.start   <= ctrl_wd.start;
        ctrl_r.enable  <= ctrl_wd.enable;
        ctrl_r.align   <= ctrl_wd.align;
        ctrl_r.channel <= ctrl_wd.channel;
      end
      // Enable written high together with the start fall sets busy.
      if (start_rise || !en_nxt)
      begin
        ctrl_r.busy <= 1'b0;
      end
      else if (start_fall)
      begin
        ctrl_r.busy <= 1'b1;
      end
      else if (done_ev)
      begin
        ctrl_r.busy <= 1'b0;
      end
    end
  end

  // Source and divider select; bits 4..3 are not implemented and stay zero.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      src_clk_r <= SRC_CLK_RST;
    end
    else if (src_wr)
    begin
      src_clk_r <= reg_wdata & 8'he7;
    end
  end

  // Reference configuration, every bit writable.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ref_r <= arc_ref_t'(REF_CTRL_RST);
    end
    else if (ref_wr)
    begin
      ref_r <= arc_ref_t'(reg_wdata);
    end
  end

  // Pin analog enables; every pin comes out of reset as an analog input.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_r <= PIN_ANALOG_RST;
    end
    else if (pin_wr)
    begin
      pin_r <= reg_wdata;
    end
  end

  // Interrupt mask; only the two event bits exist.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      int_mask_r <= INT_RST;
    end
    else if (mask_wr)
    begin
      int_mask_r <= reg_wdata & 8'h03;
    end
  end

  // Raw result, loaded only on completion while enabled.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      result_r <= RESULT_RST;
    end
    else if (done_ev)
    begin
      result_r <= conv_data;
    end
  end

  // Events of the interrupt status register, one bit per source.
  always_comb
  begin
    int_event            = '0;
    int_event[INT_DONE]  = done_ev;
    int_event[INT_ABORT] = abort_ev;
  end

  // Sticky interrupt flags; a new event wins over a write-one clear.
  for (genvar gs = 0; gs < DATA_W; gs++)
  begin : g_status
    always_ff @(posedge sys_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        int_status_r[gs] <= INT_RST[gs];
      end
      else
      begin
        int_status_r[gs] <= int_event[gs] || (int_status_r[gs] && !stat_clr[gs]);
      end
    end
  end

  // Interrupt output, one cycle behind the status and mask registers.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(int_status_r & int_mask_r);
    end
  end

  // Converter clock divide counter; restarts from zero while powered down.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_cnt_r <= '0;
    end
    else if (!ctrl_r.enable)
    begin
      div_cnt_r <= '0;
    end
    else
    begin
      div_cnt_r <= div_wrap ? '0 : div_cnt_r + DIV_ONE;
    end
  end

  // Converter clock tick; a code of zero ticks every cycle.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      conv_clk_tick <= 1'b0;
    end
    else if (!ctrl_r.enable)
    begin
      conv_clk_tick <= 1'b0;
    end
    else
    begin
      conv_clk_tick <= div_wrap;
    end
  end

  // Converter power and the one-cycle reset and start commands.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      conv_power_on <= 1'b0;
      conv_reset    <= 1'b0;
      conv_start    <= 1'b0;
    end
    else
    begin
      conv_power_on <= ctrl_r.enable;
      conv_reset    <= start_rise;
      conv_start    <= start_fall;
    end
  end

  // Input routing; an internal source always closes the external path.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mux_sel <= '0;
    end
    else
    begin
      mux_sel.ext_path_on <= src_is_ext;
      mux_sel.ext_channel <= ctrl_r.channel;
      mux_sel.int_path_on <= !src_is_ext;
      mux_sel.int_source  <= src_is_ext ? 3'h0 : src_sel;
    end
  end

  // Reference configuration handed to the analog side.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ref_cfg <= arc_ref_t'(REF_CTRL_RST);
    end
    else
    begin
      ref_cfg <= ref_r;
    end
  end

  // Per-pin analog assignment; an analog pin also loses its pull-high.
  for (genvar gp = 0; gp < PINS; gp++)
  begin : g_pin
    always_ff @(posedge sys_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        pin_analog_sel[gp]    <= PIN_ANALOG_RST[gp];
        pin_pull_high_off[gp] <= PIN_ANALOG_RST[gp];
      end
      else
      begin
        pin_analog_sel[gp]    <= pin_r[gp];
        pin_pull_high_off[gp] <= pin_r[gp];
      end
    end
  end

  // Read multiplexer; result layout follows the alignment bit.
  always_comb
  begin
    rdata_nxt = '0;
    unique case (reg_addr)
      OFS_RESULT_LOW:
        rdata_nxt = ctrl_r.align ? result_r[7:0]
                                 : {result_r[3:0], 4'h0};
      OFS_RESULT_HIGH:
        rdata_nxt = ctrl_r.align ? {4'h0, result_r[11:8]}
                                 : result_r[11:4];
      OFS_CONV_CTRL:  rdata_nxt = {ctrl_r.start, ctrl_r.busy, ctrl_r.enable,
                                   ctrl_r.align, 1'b0, ctrl_r.channel};
      OFS_SRC_CLK:    rdata_nxt = src_clk_r;
      OFS_REF_CTRL:   rdata_nxt = ref_r;
      OFS_PIN_ANALOG: rdata_nxt = pin_r;
      OFS_INT_STATUS: rdata_nxt = int_status_r;
      OFS_INT_MASK:   rdata_nxt = int_mask_r;
      default:        rdata_nxt = '0;
    endcase
  end

  // Read data stands only in the cycle after a read strobe.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata <= '0;
    end
    else
    begin
      reg_rdata <= reg_rd ? rdata_nxt : '0;
    end
  end

endmodule : arc_adc_register_control

// ===== tb/arc_checker.sv
`timescale 1ns/100ps
module arc_checker
  import arc_pkg::*;
(
  input wire logic                      sys_clk,
  input wire logic                      rstn,
  input wire logic [arc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [arc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [arc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                      conv_power_on,
  input wire logic                      conv_reset,
  input wire logic                      conv_start,
  input wire logic                      conv_clk_tick,
  input wire arc_pkg::arc_mux_t         mux_sel,
  input wire logic [arc_pkg::PINS-1:0]   pin_analog_sel,
  input wire logic [arc_pkg::PINS-1:0]   pin_pull_high_off,
  input wire logic                      irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_start_cause: assert property (conv_start |-> $past(reg_wr && reg_addr == OFS_CONV_CTRL && !reg_wdata[CC_START] && reg_wdata[CC_EN]))
    else $error("start pulse without enabled falling write");
  a_start_once: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  a_reset_cause: assert property (conv_reset |-> $past(reg_wr && reg_addr == OFS_CONV_CTRL && reg_wdata[CC_START]))
    else $error("converter reset without start write");
  a_power_copy: assert property (reg_wr && reg_addr == OFS_CONV_CTRL ##1 !(reg_wr && reg_addr == OFS_CONV_CTRL)
    |=> conv_power_on == $past(reg_wdata[CC_EN], 2))
    else $error("power output does not follow enable");
  a_tick_off: assert property (!conv_power_on && !$past(conv_power_on) |-> !conv_clk_tick)
    else $error("clock tick while powered down");
  a_mux_excl: assert property ((mux_sel.ext_path_on |-> mux_sel.int_source == 3'h0)
    and (mux_sel.int_path_on |-> !mux_sel.ext_path_on && mux_sel.int_source[1:0] != 2'h0))
    else $error("input paths not exclusive");
  a_pins_same: assert property (pin_pull_high_off == pin_analog_sel)
    else $error("pull-high removal differs from analog select");
  a_ctrl_gap: assert property (reg_rd && reg_addr == OFS_CONV_CTRL |=> reg_rdata[3] == 1'b0)
    else $error("control bit 3 not zero");
  a_src_gap: assert property (reg_rd && reg_addr == OFS_SRC_CLK |=> reg_rdata[4:3] == 2'h0)
    else $error("source register gap not zero");
  c_start: cover property (conv_start);
  c_reset: cover property (conv_reset);
  c_irq: cover property ($rose(irq));
endmodule : arc_checker

bind arc_adc_register_control arc_checker chk_u (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_power_on(conv_power_on),
  .conv_reset(conv_reset), .conv_start(conv_start), .conv_clk_tick(conv_clk_tick), .mux_sel(mux_sel),
  .pin_analog_sel(pin_analog_sel), .pin_pull_high_off(pin_pull_high_off), .irq(irq));

// ===== tb/arc_conv_model.sv
`timescale 1ns/100ps
module arc_conv_model
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        conv_start,
  input  wire logic        conv_reset,
  input  wire logic [7:0]  lat,
  input  wire logic [11:0] value,
  output logic             conv_done,
  output logic [11:0]      conv_data
);
  logic [7:0] cnt_r;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn) cnt_r <= 8'h00;
    else if (conv_reset) cnt_r <= 8'h00;
    else if (conv_start) cnt_r <= lat;
    else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
  end
  assign conv_done = (cnt_r == 8'h01);
  // Outside the done cycle the data lines carry garbage, never the result.
  assign conv_data = conv_done ? value : ~value;
endmodule : arc_conv_model

// ===== tb/arc_adc_register_control_tb_top.sv
`timescale 1ns/100ps
module arc_adc_register_control_tb_top;
  import arc_pkg::*;
  typedef struct {bit w; logic [2:0] a; logic [7:0] d;} arc_row_t;
  logic sys_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, conv_done, conv_power_on, conv_reset, conv_start;
  logic conv_clk_tick, irq;
  logic [2:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, pin_analog_sel, pin_pull_high_off, lat = 8'h05;
  logic [11:0] conv_data, value = 12'habc;
  arc_mux_t mux_sel;
  arc_ref_t ref_cfg;
  int err_total = 0, n_tests = 0, cyc = 0, k, cnt;
  arc_row_t rows[15] = '{'{0, OFS_CONV_CTRL, 8'h00}, '{0, OFS_SRC_CLK, 8'h00}, '{0, OFS_PIN_ANALOG, 8'hff},
    '{0, OFS_RESULT_HIGH, 8'h00}, '{0, OFS_INT_MASK, 8'h00}, '{1, OFS_CONV_CTRL, 8'hff},
    '{0, OFS_CONV_CTRL, 8'hb7}, '{1, OFS_SRC_CLK, 8'hff}, '{0, OFS_SRC_CLK, 8'he7}, '{1, OFS_REF_CTRL, 8'h5a},
    '{0, OFS_REF_CTRL, 8'h5a}, '{1, OFS_PIN_ANALOG, 8'h0f}, '{0, OFS_PIN_ANALOG, 8'h0f},
    '{1, OFS_RESULT_LOW, 8'h55}, '{0, OFS_RESULT_LOW, 8'h00}};
  always #5 sys_clk = ~sys_clk;
  arc_adc_register_control dut_u (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done), .conv_data(conv_data),
    .conv_power_on(conv_power_on), .conv_reset(conv_reset), .conv_start(conv_start),
    .conv_clk_tick(conv_clk_tick), .mux_sel(mux_sel), .ref_cfg(ref_cfg), .pin_analog_sel(pin_analog_sel),
    .pin_pull_high_off(pin_pull_high_off), .irq(irq));
  arc_conv_model core_u (.sys_clk(sys_clk), .rstn(rstn), .conv_start(conv_start), .conv_reset(conv_reset),
    .lat(lat), .value(value), .conv_done(conv_done), .conv_data(conv_data));
  task chk(input logic [11:0] s, input logic [11:0] e);
    n_tests++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  // Software start sequence: start high, then low with the wanted settings.
  task go(input logic [7:0] c);
    wr(OFS_CONV_CTRL, c | 8'h80);
    wr(OFS_CONV_CTRL, c);
    k = 0;
    while (!conv_done && k < 300)
    begin
      @(posedge sys_clk); #1 k++;
    end
    @(posedge sys_clk);
  endtask : go
  task wrap_up;
    $display("counts: %0d compares, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    foreach (rows[i]) if (rows[i].w) wr(rows[i].a, rows[i].d); else rd(rows[i].a, rows[i].d);
    chk(pin_analog_sel, 8'h0f); chk(pin_pull_high_off, 8'h0f); chk(ref_cfg, 8'h5a);
    $display("register table test done");
    wr(OFS_INT_MASK, 8'h01); go(8'h20);
    rd(OFS_CONV_CTRL, 8'h20); rd(OFS_RESULT_HIGH, 8'hab); rd(OFS_RESULT_LOW, 8'hc0);
    chk(irq, 1'b1); rd(OFS_INT_STATUS, 8'h01);
    wr(OFS_CONV_CTRL, 8'h30); rd(OFS_RESULT_HIGH, 8'h0a); rd(OFS_RESULT_LOW, 8'hbc);
    wr(OFS_INT_STATUS, 8'h01); wr(OFS_INT_MASK, 8'h00); rd(OFS_INT_STATUS, 8'h00); chk(irq, 1'b0);
    value = 12'h123; go(8'h30); rd(OFS_RESULT_LOW, 8'h23); chk(irq, 1'b0);
    rd(OFS_INT_STATUS, 8'h01); wr(OFS_INT_STATUS, 8'h01);
    value = 12'h456; go(8'h00); rd(OFS_CONV_CTRL, 8'h00); rd(OFS_RESULT_HIGH, 8'h12);
    wr(OFS_CONV_CTRL, 8'ha0); wr(OFS_CONV_CTRL, 8'h20); wr(OFS_CONV_CTRL, 8'h00); repeat (8) @(posedge sys_clk);
    rd(OFS_RESULT_HIGH, 8'h12); rd(OFS_INT_STATUS, 8'h00);
    $display("conversion test done");
    lat = 8'hc8; go(8'h20); rd(OFS_RESULT_LOW, 8'h60); wr(OFS_INT_STATUS, 8'h01);
    wr(OFS_CONV_CTRL, 8'ha0); wr(OFS_CONV_CTRL, 8'h20); rd(OFS_CONV_CTRL, 8'h60);
    wr(OFS_CONV_CTRL, 8'ha0); rd(OFS_CONV_CTRL, 8'ha0); rd(OFS_INT_STATUS, 8'h02);
    $display("abort test done");
    for (k = 0; k < 8; k++)
    begin
      wr(OFS_CONV_CTRL, 8'h20 | k[7:0]); wr(OFS_SRC_CLK, {k[2:0], 5'h00}); repeat (2) @(posedge sys_clk);
      chk(mux_sel.ext_path_on, k[1:0] == 2'h0); chk(mux_sel.int_source, k[1:0] == 2'h0 ? 3'h0 : k[2:0]);
      chk(mux_sel.int_path_on, k[1:0] != 2'h0);
      if (k[1:0] == 2'h0) chk(mux_sel.ext_channel, k[2:0]);
    end
    for (k = 0; k < 8; k++)
    begin
      wr(OFS_SRC_CLK, k[7:0]); repeat (4) @(posedge sys_clk); cnt = 0;
      repeat (256) begin @(posedge sys_clk); #1 cnt += conv_clk_tick; end
      chk(cnt[11:0], 12'h100 >> k);
    end
    $display("mux and divider test done");
    wrap_up();
  end
endmodule : arc_adc_register_control_tb_top
